// *** hdl/status_pkg.sv ***
// constants and types of the status byte and service request block
// Summary of operation
// - service request enable register, read and write
// - enable position 6 ignored for requests
// - enabled status bit rising raises request
// - status byte returned on query or poll
// - position 1 carries device state summary
// - position 2 set while error queue nonempty
// - position 3 is questionable summary
// - position 4 set when message available
// - position 5 is standard event summary
// - position 6 is master summary
// - position 7 is operation summary
// - flag ORs status bits masked by poll enable
// - poll enable writable, flag reported
// - condition live, event latched since read
// - sensor attach and error positions
// - sensor front zero, rear one
// - position 14 key held or pressed
// - position 15 always zero
// - rising edge sets event if rise filter
// - falling edge sets event if fall filter
// - event read returns and clears
// - summary is OR of enabled events
package status_pkg;
   localparam int STB_W = 8;
   localparam int DEV_W = 16;
   // status byte positions
   localparam int POS_DEV  = 1;
   localparam int POS_ERRQ = 2;
   localparam int POS_QUES = 3;
   localparam int POS_MAV  = 4;
   localparam int POS_ESB  = 5;
   localparam int POS_MSS  = 6;
   localparam int POS_OPER = 7;
   // device state positions
   localparam int DPOS_KEY = 14;
   localparam logic [15:0] DEV_USED_MASK = 16'h5ffe;
   localparam logic [15:0] DEV_RISE_RST  = 16'h7fff;
   localparam logic [15:0] DEV_FALL_RST  = 16'h0000;
   localparam logic [15:0] DEV_EN_RST    = 16'h0000;
   localparam logic [7:0]  SRE_RST       = 8'h00;
   localparam logic [7:0]  PPE_RST       = 8'h00;
   localparam logic [7:0]  SRE_USED_MASK = 8'hbf;
   localparam logic [7:0]  STB_USED_MASK = 8'hfe;
   typedef logic [3:0] sensor_vec_t;
endpackage

// *** hdl/event_reg_if.sv ***
// carrier between the status top and its event register stage
`timescale 1ns/1ps
interface event_reg_if #(parameter int W = 16);
   logic [W-1:0] cond;
   logic [W-1:0] rise_filter;
   logic [W-1:0] fall_filter;
   logic [W-1:0] enable;
   logic         read_clear;
   logic [W-1:0] event_bits;
   logic         summary;
   modport owner (output cond, rise_filter, fall_filter, enable,
                  read_clear, input event_bits, summary);
   modport stage (input cond, rise_filter, fall_filter, enable,
                  read_clear, output event_bits, summary);
endinterface

// *** hdl/event_reg.sv ***
// transition filtered event register with summary
`timescale 1ns/1ps
module event_reg #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   event_reg_if.stage bus
);
   logic [W-1:0] cond_q;
   logic [W-1:0] next_event;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cond_q <= '0;
      end else begin
         cond_q <= bus.cond;
      end
   end

   always_comb begin
      // read clears, but an edge in the same cycle still lands
      next_event = bus.read_clear ? '0 : bus.event_bits;
      next_event = next_event | (bus.cond & ~cond_q & bus.rise_filter);
      next_event = next_event | (~bus.cond & cond_q & bus.fall_filter);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus.event_bits <= '0;
      end else begin
         bus.event_bits <= next_event;
      end
   end

   assign bus.summary = |(bus.event_bits & bus.enable);
endmodule // event_reg

// *** hdl/status_byte_service_request.sv ***
// status byte, service request, individual flag and device state register
`timescale 1ns/1ps
module status_byte_service_request
   import status_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   // lower-level summaries and queue flags
   input  wire logic                     error_queue_nonempty,
   input  wire logic                     error_queue_push,
   input  wire logic                     message_available,
   input  wire logic                     questionable_summary,
   input  wire logic                     standard_event_summary,
   input  wire logic                     operation_summary,
   // live device states
   input  wire status_pkg::sensor_vec_t  sensor_attached,
   input  wire status_pkg::sensor_vec_t  sensor_error,
   input  wire status_pkg::sensor_vec_t  sensor_rear,
   input  wire logic                     key_held,
   // controller accesses from the command parser
   input  wire logic                     sre_write,
   input  wire logic [7:0]               sre_wdata,
   input  wire logic                     ppe_write,
   input  wire logic [7:0]               ppe_wdata,
   input  wire logic                     dev_enable_write,
   input  wire logic                     dev_rise_write,
   input  wire logic                     dev_fall_write,
   input  wire logic [15:0]              dev_wdata,
   input  wire logic                     dev_event_read,
   // readback
   output logic      [7:0]               status_summary_byte,
   output logic      [7:0]               service_request_enable,
   output logic      [7:0]               parallel_poll_enable,
   output logic                          individual_status_flag,
   output logic      [15:0]              dev_condition,
   output logic      [15:0]              dev_event_rdata,
   output logic      [15:0]              dev_enable,
   output logic      [15:0]              dev_rise_filter,
   output logic      [15:0]              dev_fall_filter,
   output logic                          service_request
);
   import status_pkg::*;

   event_reg_if #(.W(DEV_W)) dev_if ();

   logic [15:0] next_cond;
   logic [7:0]  next_stb;
   logic [7:0]  stb_q;
   logic        master_summary;
   logic        srq_cause;

   //--------------------------------------------------
   // device state register
   //--------------------------------------------------
   always_comb begin
      next_cond = '0;
      next_cond[1]  = sensor_attached[0];
      next_cond[2]  = sensor_attached[1];
      next_cond[7]  = sensor_attached[2];
      next_cond[8]  = sensor_attached[3];
      next_cond[3]  = sensor_error[0];
      next_cond[4]  = sensor_error[1];
      next_cond[9]  = sensor_error[2];
      next_cond[10] = sensor_error[3];
      next_cond[5]  = sensor_rear[0];
      next_cond[6]  = sensor_rear[1];
      next_cond[11] = sensor_rear[2];
      next_cond[12] = sensor_rear[3];
      next_cond[DPOS_KEY] = key_held;
      next_cond = next_cond & DEV_USED_MASK;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dev_condition <= '0;
      end else begin
         dev_condition <= next_cond;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dev_enable      <= DEV_EN_RST;
         dev_rise_filter <= DEV_RISE_RST;
         dev_fall_filter <= DEV_FALL_RST;
      end else begin
         if (dev_enable_write) begin
            dev_enable <= dev_wdata & DEV_USED_MASK;
         end
         if (dev_rise_write) begin
            dev_rise_filter <= dev_wdata & DEV_USED_MASK;
         end
         if (dev_fall_write) begin
            dev_fall_filter <= dev_wdata & DEV_USED_MASK;
         end
      end
   end

   assign dev_if.cond        = dev_condition;
   assign dev_if.rise_filter = dev_rise_filter;
   assign dev_if.fall_filter = dev_fall_filter;
   assign dev_if.enable      = dev_enable;
   assign dev_if.read_clear  = dev_event_read;
   // key pressed latched in event part
   assign dev_event_rdata    = dev_if.event_bits;

   event_reg #(.W(DEV_W)) u_dev_event (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .bus      (dev_if)
   );

   //--------------------------------------------------
   // enable registers
   //--------------------------------------------------
   // service request enable
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         service_request_enable <= SRE_RST;
      end else if (sre_write) begin
         service_request_enable <= sre_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         parallel_poll_enable <= PPE_RST;
      end else if (ppe_write) begin
         parallel_poll_enable <= ppe_wdata;
      end
   end

   //--------------------------------------------------
   // status byte
   //--------------------------------------------------
   always_comb begin
      next_stb = '0;
      next_stb[POS_DEV]  = dev_if.summary;
      next_stb[POS_ERRQ] = error_queue_nonempty;
      next_stb[POS_QUES] = questionable_summary;
      next_stb[POS_MAV]  = message_available;
      next_stb[POS_ESB]  = standard_event_summary;
      next_stb[POS_OPER] = operation_summary;
      next_stb = next_stb & STB_USED_MASK;
      // master summary, enable bit 6 ignored
      master_summary = |(next_stb & service_request_enable & SRE_USED_MASK);
      next_stb[POS_MSS] = master_summary;
   end

   // rising enabled bit; every new error entry requests again while position 2 is enabled
   assign srq_cause = |((next_stb & ~stb_q) & service_request_enable
                        & SRE_USED_MASK)
                      | (error_queue_push & service_request_enable[POS_ERRQ]);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stb_q <= '0;
      end else begin
         stb_q <= next_stb;
      end
   end

   // current byte for query and serial poll
   assign status_summary_byte = stb_q;

   // request raised on edge, held until nothing enabled remains
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         service_request <= 1'b0;
      end else if (srq_cause) begin
         service_request <= 1'b1;
      end else if (!master_summary) begin
         service_request <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         individual_status_flag <= 1'b0;
      end else begin
         individual_status_flag <= |(next_stb & parallel_poll_enable);
      end
   end
endmodule // status_byte_service_request

// *** test/status_sva.sv ***
// assertions on the status byte block ports
`timescale 1ns/1ps
module status_sva (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        error_queue_nonempty,
   input wire logic        error_queue_push,
   input wire logic        message_available,
   input wire logic        questionable_summary,
   input wire logic        standard_event_summary,
   input wire logic        operation_summary,
   input wire logic        dev_event_read,
   input wire logic [7:0]  status_summary_byte,
   input wire logic [7:0]  service_request_enable,
   input wire logic [7:0]  parallel_poll_enable,
   input wire logic        individual_status_flag,
   input wire logic [15:0] dev_condition,
   input wire logic [15:0] dev_event_rdata,
   input wire logic [15:0] dev_rise_filter,
   input wire logic [15:0] dev_fall_filter,
   input wire logic        service_request
);
   logic [15:0] prev_cond;
   logic [15:0] edge_hit;
   wire  [7:0]  stb = status_summary_byte;
   wire  [7:0]  en  = service_request_enable & 8'hbf;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) prev_cond <= 16'h0000;
      else prev_cond <= dev_condition;
   end
   assign edge_hit = (dev_condition & ~prev_cond & dev_rise_filter)
                   | (~dev_condition & prev_cond & dev_fall_filter);
   sequence s_none;
      !(|(stb & en)) && !error_queue_push;
   endsequence
   a_stb_inputs: assert property (
      !$past(sys_rst) |-> {stb[7], stb[5:2]} == {$past(operation_summary),
      $past(standard_event_summary), $past(message_available),
      $past(questionable_summary), $past(error_queue_nonempty)})
      else $error("status bits do not follow inputs");
   a_unused_zero: assert property (
      !stb[0] && (dev_condition & 16'ha001) == 16'h0000)
      else $error("unused bit set");
   a_master_sum: assert property (
      $stable(stb) && $stable(en) |-> stb[6] == |(stb & en))
      else $error("master summary wrong");
   a_flag_ppe: assert property (
      $stable(stb) && $stable(parallel_poll_enable)
      |-> individual_status_flag == |(stb & parallel_poll_enable))
      else $error("individual flag wrong");
   a_sreq_rise: assert property (
      |(stb & ~$past(stb) & en) |-> ##[0:1] service_request)
      else $error("no request on enabled rise");
   a_push_req: assert property (
      error_queue_push && service_request_enable[2] |=> service_request)
      else $error("no request on queue push");
   a_sreq_drop: assert property (
      s_none [*3] |-> !service_request)
      else $error("request held with nothing enabled");
   a_event_edge: assert property (
      |edge_hit |=> (dev_event_rdata & $past(edge_hit)) == $past(edge_hit))
      else $error("filtered edge not latched");
   a_event_clear: assert property (
      dev_event_read |=> (dev_event_rdata & ~$past(edge_hit)) == 16'h0000)
      else $error("event read did not clear");
endmodule // status_sva
bind status_byte_service_request status_sva u_sva (.*);

// *** test/bus_ctl.sv ***
// controller model: enable register writes and event reads
`timescale 1ns/1ps
module bus_ctl (
   input  wire logic        core_clk,
   input  wire logic [15:0] dev_event_rdata,
   output logic             sre_write,
   output logic [7:0]       sre_wdata,
   output logic             ppe_write,
   output logic [7:0]       ppe_wdata,
   output logic             dev_event_read
);
   initial begin
      {sre_write, ppe_write, dev_event_read} = 3'b000;
      {sre_wdata, ppe_wdata} = 16'h0000;
   end
   task automatic wr(input logic [7:0] s, input logic [7:0] p);
      @(posedge core_clk);
      {sre_write, ppe_write} <= 2'b11;
      {sre_wdata, ppe_wdata} <= {s, p};
      @(posedge core_clk);
      {sre_write, ppe_write} <= 2'b00;
      // released data no longer shows the written value
      {sre_wdata, ppe_wdata} <= ~{s, p};
   endtask
   task automatic rd(output logic [15:0] d);
      @(posedge core_clk);
      dev_event_read <= 1'b1;
      @(posedge core_clk);
      d = dev_event_rdata;
      dev_event_read <= 1'b0;
   endtask
endmodule // bus_ctl

// *** test/status_byte_service_request_test.sv ***
// self-checking bench for the status byte block
`timescale 1ns/1ps
module status_byte_service_request_test;
   import status_pkg::*;
   logic        core_clk, sys_rst, error_queue_push, key_held;
   logic        error_queue_nonempty, message_available;
   logic        questionable_summary, standard_event_summary;
   logic        operation_summary, service_request;
   logic        sre_write, ppe_write, dev_event_read;
   logic        dev_enable_write, dev_rise_write, dev_fall_write;
   logic        individual_status_flag;
   sensor_vec_t sensor_attached, sensor_error, sensor_rear;
   logic [7:0]  sre_wdata, ppe_wdata, status_summary_byte;
   logic [7:0]  service_request_enable, parallel_poll_enable;
   logic [15:0] dev_wdata, dev_condition, dev_event_rdata, dev_enable;
   logic [15:0] dev_rise_filter, dev_fall_filter, rd_val;
   logic [4:0]  drv;
   logic [29:0] rows [5];
   int          n_fail, n_compared;
   assign {operation_summary, standard_event_summary, message_available,
           questionable_summary, error_queue_nonempty} = drv;
   status_byte_service_request uut (.*);
   bus_ctl ctl (.*);
   // row: inputs, enable, poll enable, status byte, flag
   // the request is expected to follow the master bit of each row
   initial rows = '{
      {5'h01, 8'h04, 8'h00, 8'h44, 1'b0},
      {5'h04, 8'h40, 8'h40, 8'h10, 1'b0},
      {5'h1f, 8'hff, 8'h40, 8'hfc, 1'b1},
      {5'h10, 8'h00, 8'h80, 8'h80, 1'b1},
      {5'h0a, 8'h08, 8'h01, 8'h68, 1'b0}};
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic dwr(input logic [2:0] s, input logic [15:0] d);
      @(posedge core_clk);
      {dev_enable_write, dev_rise_write, dev_fall_write} <= s;
      dev_wdata <= d;
      @(posedge core_clk);
      {dev_enable_write, dev_rise_write, dev_fall_write} <= 3'b000;
      dev_wdata <= ~d;
   endtask
   task automatic finish_test;
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // a hang is cut off well past the 73 cycles needed
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
   initial begin
      {sys_rst, error_queue_push, key_held, drv} = 8'h80;
      {sensor_attached, sensor_error, sensor_rear} = 12'h000;
      {dev_enable_write, dev_rise_write, dev_fall_write} = 3'b000;
      dev_wdata = 16'h0000;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         ctl.wr(rows[i][24:17], rows[i][16:9]);
         drv <= rows[i][29:25];
         repeat (4) @(posedge core_clk);
         chk("stb", 16'(status_summary_byte), 16'(rows[i][8:1]));
         chk("flag", 16'(individual_status_flag), 16'(rows[i][0]));
         chk("srq", 16'(service_request), 16'(rows[i][7]));
         chk("sre", 16'(service_request_enable), 16'(rows[i][24:17]));
         chk("ppe", 16'(parallel_poll_enable), 16'(rows[i][16:9]));
      end
      // ------------------------------
      // device state register
      // ------------------------------
      ctl.wr(8'h02, 8'h02);
      {sensor_attached, sensor_error, sensor_rear} <= 12'ha18;
      key_held <= 1'b1;
      dwr(3'b100, 16'hffff);
      repeat (6) @(posedge core_clk);
      chk("cond", dev_condition, 16'h510c);
      chk("enable", dev_enable, 16'h5ffe);
      chk("stb", 16'(status_summary_byte), 16'h006a);
      chk("srq", 16'(service_request), 16'h0001);
      ctl.rd(rd_val);
      chk("read", rd_val, 16'h510c);
      @(posedge core_clk);
      chk("cleared", dev_event_rdata, 16'h0000);
      dwr(3'b001, 16'hffff);
      dwr(3'b010, 16'h0000);
      // the last write lands at the edge the task returns on
      @(posedge core_clk);
      chk("fall", dev_fall_filter, 16'h5ffe);
      chk("rise", dev_rise_filter, 16'h0000);
      sensor_attached[0] <= 1'b1;
      key_held <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("event", dev_event_rdata, 16'h4000);
      // error bit already set when enabled: only a push may request
      drv <= 5'h01;
      ctl.wr(8'h00, 8'h00);
      ctl.wr(8'h04, 8'h00);
      repeat (2) @(posedge core_clk);
      chk("no rise", 16'(service_request), 16'h0000);
      error_queue_push <= 1'b1;
      @(posedge core_clk);
      error_queue_push <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("push", 16'(service_request), 16'h0001);
      drv <= 5'h00;
      repeat (4) @(posedge core_clk);
      chk("drop", 16'(service_request), 16'h0000);
      chk("stb", 16'(status_summary_byte), 16'h0002);
      // ------------------------------
      // reset in mid-run
      // ------------------------------
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      chk("rise", dev_rise_filter, 16'h7fff);
      chk("fall", dev_fall_filter, 16'h0000);
      chk("sre", 16'(service_request_enable), 16'h0000);
      chk("stb", 16'(status_summary_byte), 16'h0000);
      // live states come back as rising edges after release
      repeat (3) @(posedge core_clk);
      chk("cond", dev_condition, 16'h110e);
      chk("event", dev_event_rdata, 16'h110e);
      finish_test();
   end
endmodule // status_byte_service_request_test
